//--- rtl/ppct_pkg.sv
// ==========================================================
// shared widths, field positions and reset values
package ppct_pkg;
    // counter, prescaler and dead-zone widths
    localparam int CNT_W = 16;
    localparam int PRE_W = 8;
    localparam int DZ_W = 8;
    localparam int SEL_W = 3;
    localparam int DIV_W = 4;
    localparam int NCH = 4;
    localparam int NPAIR = 2;
    // field positions inside one half of a capture control word
    localparam int CC_INV_BIT = 0;
    localparam int CC_RISE_IE_BIT = 1;
    localparam int CC_FALL_IE_BIT = 2;
    localparam int CC_CAP_EN_BIT = 3;
    // second channel of a control word sits in the upper half
    localparam int CC_HI_OFS = 16;
    // divider select codes are shift counts, largest is divide by 16
    localparam logic [SEL_W-1:0] SEL_DIV16 = 3'h4;
    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
    localparam logic [DZ_W-1:0] DZ_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
    // channel timer states
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} ppct_state_t;
endpackage

//--- rtl/ppct_channel.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one channel timer: double-buffered period and compare,
// 16-bit down-counter, comparator
module ppct_channel #(
    parameter int W = 16
) (
    input wire logic clk, // block clock
    input wire logic rst, // synchronous reset
    input wire logic tick, // divided channel clock enable
    input wire logic run, // channel run enable
    input wire logic auto_reload, // 1 auto-reload, 0 one-shot
    input wire logic period_wr, // period buffer write strobe
    input wire logic compare_wr, // compare buffer write strobe
    input wire logic [W-1:0] wdata, // write data for both buffers
    input wire logic cap_reload, // capture flag raised this cycle
    output logic [W-1:0] count_ff, // live counter value
    output logic zero_ff, // pulse: counter just reached zero
    output logic high // comparator output
);
    logic [W-1:0] per_buf_ff;
    logic [W-1:0] cmp_buf_ff;
    logic [W-1:0] cmp_act_ff;
    ppct_pkg::ppct_state_t state_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // buffer registers, written at any time
    // RQ5: software writes land in buffers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            per_buf_ff <= W'(ppct_pkg::CNT_RST);
            cmp_buf_ff <= W'(ppct_pkg::CNT_RST);
        end
        else
        begin
            if (period_wr)
                per_buf_ff <= wdata;
            if (compare_wr)
                cmp_buf_ff <= wdata;
        end
    end

    // ==========================================================
    // counter; active compare only changes at a period boundary
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ppct_pkg::ST_IDLE;
            count_ff <= W'(ppct_pkg::CNT_RST);
            cmp_act_ff <= W'(ppct_pkg::CNT_RST);
            zero_ff <= 1'b0;
        end
        else
        begin
            zero_ff <= 1'b0;
            // RQ21: dropping run stops at once
            if (!run)
                state_ff <= ppct_pkg::ST_IDLE;
            else
                unique case (state_ff)
                    ppct_pkg::ST_IDLE:
                    begin
                        count_ff <= per_buf_ff;
                        cmp_act_ff <= cmp_buf_ff;
                        state_ff <= ppct_pkg::ST_RUN;
                    end
                    ppct_pkg::ST_RUN:
                    begin
                        // RQ16: capture reloads the counter
                        if (cap_reload)
                        begin
                            count_ff <= per_buf_ff;
                            cmp_act_ff <= cmp_buf_ff;
                        end
                        // RQ24: count down on each tick
                        else if (tick && count_ff != '0)
                        begin
                            count_ff <= count_ff - W'(1);
                            // RQ3: zero reached event
                            zero_ff <= (count_ff == W'(1));
                        end
                        // RQ6 RQ11: reload, or halt on zero period
                        else if (tick && auto_reload && per_buf_ff != '0)
                        begin
                            count_ff <= per_buf_ff;
                            cmp_act_ff <= cmp_buf_ff;
                        end
                        // RQ7: one-shot stops after its single cycle
                        else if (tick)
                            state_ff <= ppct_pkg::ST_HALT;
                    end
                    ppct_pkg::ST_HALT:
                        state_ff <= ppct_pkg::ST_HALT;
                endcase
        end
    end

    // RQ8 RQ10: high while counter at or below compare
    assign high = (state_ff == ppct_pkg::ST_RUN) && (count_ff <= cmp_act_ff);

    // RQ12 compare held mid-cycle
    cmp_hold_a: assert property ( // RQ12
        (state_ff == ppct_pkg::ST_RUN && run && !cap_reload
         && !(tick && count_ff == '0)) |=> $stable(cmp_act_ff))
        else $error("active compare changed inside a period");
    // RQ16 capture reload
    cap_reload_a: assert property ( // RQ16
        (run && cap_reload && state_ff == ppct_pkg::ST_RUN)
        |=> count_ff == $past(per_buf_ff))
        else $error("counter not reloaded on capture");
endmodule
`default_nettype wire

//--- rtl/ppct_group.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Overview of operation
// RQ1: four channels, independent or as pairs (0,1),(2,3), dead zone per pair
// RQ2: per generator an 8-bit prescaler then divide by 1, 2, 4, 8 or 16
// RQ3: period counter reaching zero sets channel flag; enable gates the interrupt
// RQ4: with pair dead zone on, odd output is complement of even channel
// RQ5: period and compare writes go to buffers, loaded at zero
// RQ6: auto-reload mode reloads from period at zero and keeps counting
// RQ7: one-shot mode stops at zero after exactly one interrupt
// RQ8: output goes high when counter matches compare
// RQ9: frequency is clock/(prescale+1)/divider/(period+1)
// RQ10: compare at or above period gives constant high; else high compare+1
// RQ11: reload-mode one means auto-reload, zero one-shot; zero period halts
// RQ12: a compare write takes effect only from the next cycle
// RQ13: dead zone delays rising edges of the pair by the interval
// RQ14: capture latches counter on rising and falling input edges
// RQ15: capture interrupt enables at bits 1,2 and 17,18 per control word
// RQ16: raising a capture flag reloads that channel's counter from period
// RQ17: pulse widths read as period+1 minus the latch value
// RQ18: PWM and capture share one channel line, merged into one group line
// RQ19: flags clear when software writes one to them
// RQ20: software routes pins: output enable for PWM, capture enable for capture
// RQ21: clearing run enable stops output immediately, even mid-period
// RQ22: software sets all configuration before setting run enable
// RQ23: dead-zone interval is 8 bits in units of the pair's divided clock
// RQ24: counter decrements once per divided clock tick while running
module ppct_group (
    input wire logic CLOCK, // 20 MHz block clock
    input wire logic RST, // synchronous reset, active high
    input wire logic [7:0] PRESCALE_SETTING_01, // prescale, channels 0 and 1
    input wire logic [7:0] PRESCALE_SETTING_23, // prescale, channels 2 and 3
    input wire logic [11:0] CLOCK_SELECT, // 3-bit divider code per channel
    input wire logic [7:0] DEADZONE_INTERVAL_01, // dead time, pair 0/1
    input wire logic [7:0] DEADZONE_INTERVAL_23, // dead time, pair 2/3
    input wire logic [1:0] PAIR_DEADZONE_ENABLE, // complementary pair mode
    input wire logic [3:0] CHANNEL_RUN_ENABLE, // run per channel
    input wire logic [3:0] CHANNEL_RELOAD_MODE, // 1 auto-reload, 0 one-shot
    input wire logic [3:0] PERIOD_WR, // period write strobe per channel
    input wire logic [3:0] COMPARE_WR, // compare write strobe per channel
    input wire logic [15:0] WRITE_DATA, // data for the strobes
    input wire logic [3:0] INTERRUPT_ENABLE_BITS, // period interrupt enable
    input wire logic [3:0] INDICATION_CLEAR, // write-one-clear, period flags
    input wire logic [31:0] CAPTURE_CONTROL_LOW, // capture control, ch 0 and 1
    input wire logic [31:0] CAPTURE_CONTROL_HIGH, // capture control, ch 2 and 3
    input wire logic [3:0] CAPTURE_FLAG_CLEAR, // write-one-clear, capture flags
    input wire logic [3:0] PIN_OUTPUT_ENABLE, // route pin as output
    input wire logic [3:0] CAPTURE_INPUT_ENABLE, // route pin as capture input
    input wire logic [3:0] CAPTURE_PIN, // asynchronous capture inputs
    output logic [3:0] PWM_OUT, // channel pin outputs
    output logic [3:0] PWM_OE, // pin driven while high
    output logic [3:0] INTERRUPT_INDICATION, // sticky period flags
    output logic [3:0] CAPTURE_FLAG, // sticky capture flags
    output logic GROUP_INTERRUPT, // merged group interrupt
    output logic [15:0] COUNTER_READBACK0, // live counter, channel 0
    output logic [15:0] COUNTER_READBACK1, // live counter, channel 1
    output logic [15:0] COUNTER_READBACK2, // live counter, channel 2
    output logic [15:0] COUNTER_READBACK3, // live counter, channel 3
    output logic [15:0] RISING_CAPTURE_LATCH0, // rising latch, channel 0
    output logic [15:0] RISING_CAPTURE_LATCH1, // rising latch, channel 1
    output logic [15:0] RISING_CAPTURE_LATCH2, // rising latch, channel 2
    output logic [15:0] RISING_CAPTURE_LATCH3, // rising latch, channel 3
    output logic [15:0] FALLING_CAPTURE_LATCH0, // falling latch, channel 0
    output logic [15:0] FALLING_CAPTURE_LATCH1, // falling latch, channel 1
    output logic [15:0] FALLING_CAPTURE_LATCH2, // falling latch, channel 2
    output logic [15:0] FALLING_CAPTURE_LATCH3 // falling latch, channel 3
);
    localparam int NCH = ppct_pkg::NCH;
    localparam int NPAIR = ppct_pkg::NPAIR;
    localparam int W = ppct_pkg::CNT_W;

    logic [ppct_pkg::PRE_W-1:0] pre_cnt_ff [NPAIR];
    logic [NPAIR-1:0] pre_tick;
    logic [ppct_pkg::DIV_W-1:0] div_cnt_ff [NCH];
    logic [NCH-1:0] tick;
    logic [W-1:0] cnt [NCH];
    logic [NCH-1:0] zero;
    logic [NCH-1:0] high;
    logic [NCH-1:0] cap_s1_ff;
    logic [NCH-1:0] cap_s2_ff;
    logic [NCH-1:0] cap_prev_ff;
    logic [NCH-1:0] cap_in;
    logic [NCH-1:0] cap_en;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    logic [NCH-1:0] cap_set;
    logic [W-1:0] rise_lat_ff [NCH];
    logic [W-1:0] fall_lat_ff [NCH];
    logic [ppct_pkg::DZ_W-1:0] dz_cnt_ff [NPAIR];
    logic [NPAIR-1:0] raw_prev_ff;
    logic [NPAIR-1:0] gap;
    logic [NCH-1:0] nxt_pwm;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // picks one field bit of a channel out of the two control words
    function automatic logic cc_bit(input int ch, input int pos);
        logic [31:0] word;
        word = (ch < 2) ? CAPTURE_CONTROL_LOW : CAPTURE_CONTROL_HIGH;
        return word[(ch % 2) * ppct_pkg::CC_HI_OFS + pos];
    endfunction

    // all-ones mask of the divider code; codes above divide-by-16 clamp
    function automatic logic [ppct_pkg::DIV_W-1:0] div_mask(
        input logic [ppct_pkg::SEL_W-1:0] sel);
        logic [ppct_pkg::SEL_W-1:0] s;
        s = (sel > ppct_pkg::SEL_DIV16) ? ppct_pkg::SEL_DIV16 : sel;
        return ppct_pkg::DIV_W'((5'h01 << s) - 5'h01);
    endfunction

    // ==========================================================
    // prescalers, one per generator
    // RQ2 RQ9: tick every prescale+1 clocks
    always_ff @(posedge CLOCK)
    begin
        for (int p = 0; p < NPAIR; p++)
        begin
            if (RST || pre_tick[p])
                pre_cnt_ff[p] <= ppct_pkg::PRE_RST;
            else
                pre_cnt_ff[p] <= pre_cnt_ff[p] + 8'h01;
        end
    end

    assign pre_tick[0] = (pre_cnt_ff[0] == PRESCALE_SETTING_01);
    assign pre_tick[1] = (pre_cnt_ff[1] == PRESCALE_SETTING_23);

    // ==========================================================
    // clock dividers, one selector per channel
    // RQ2: divide by 1, 2, 4, 8 or 16
    always_ff @(posedge CLOCK)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (RST)
                div_cnt_ff[c] <= ppct_pkg::DIV_RST;
            else if (pre_tick[c / 2])
                div_cnt_ff[c] <= div_cnt_ff[c] + 4'h1;
        end
    end

    // divider tick fires when the selected low bits are all ones
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            tick[c] = pre_tick[c / 2]
                && ((div_cnt_ff[c] & div_mask(CLOCK_SELECT[c*3 +: 3]))
                    == div_mask(CLOCK_SELECT[c*3 +: 3]));
        end
    end

    // ==========================================================
    // channel timers
    for (genvar g = 0; g < NCH; g++)
    begin : gen_ch
        ppct_channel #(
            .W(W)
        ) u_ch (
            .clk(CLOCK),
            .rst(RST),
            .tick(tick[g]),
            .run(CHANNEL_RUN_ENABLE[g]),
            .auto_reload(CHANNEL_RELOAD_MODE[g]),
            .period_wr(PERIOD_WR[g]),
            .compare_wr(COMPARE_WR[g]),
            .wdata(WRITE_DATA),
            .cap_reload(cap_set[g]),
            .count_ff(cnt[g]),
            .zero_ff(zero[g]),
            .high(high[g])
        );
    end

    // ==========================================================
    // capture inputs: two flops, then edge detection
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cap_s1_ff <= '0;
            cap_s2_ff <= '0;
            cap_prev_ff <= '0;
        end
        else
        begin
            cap_s1_ff <= CAPTURE_PIN;
            cap_s2_ff <= cap_s1_ff;
            cap_prev_ff <= cap_in;
        end
    end

    // optional inversion; toggling it may fake one edge
    // RQ15: interrupt conditions per channel enable bits
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            cap_in[c] = cap_s2_ff[c] ^ cc_bit(c, ppct_pkg::CC_INV_BIT);
            cap_en[c] = cc_bit(c, ppct_pkg::CC_CAP_EN_BIT);
            rise[c] = cap_en[c] && cap_in[c] && !cap_prev_ff[c];
            fall[c] = cap_en[c] && !cap_in[c] && cap_prev_ff[c];
            cap_set[c] = (rise[c] && cc_bit(c, ppct_pkg::CC_RISE_IE_BIT))
                || (fall[c] && cc_bit(c, ppct_pkg::CC_FALL_IE_BIT));
        end
    end

    // ==========================================================
    // capture latches; the counter runs down, so pulse width
    // is period+1 minus the latched value
    // RQ14 RQ17: latch live counter on each edge
    always_ff @(posedge CLOCK)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (RST)
            begin
                rise_lat_ff[c] <= ppct_pkg::CNT_RST;
                fall_lat_ff[c] <= ppct_pkg::CNT_RST;
            end
            else
            begin
                if (rise[c])
                    rise_lat_ff[c] <= cnt[c];
                if (fall[c])
                    fall_lat_ff[c] <= cnt[c];
            end
        end
    end

    // ==========================================================
    // sticky flags; a set in the clear cycle wins
    // RQ3 RQ19: set on zero, clear on write one
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            INTERRUPT_INDICATION <= '0;
        else
            INTERRUPT_INDICATION <= (INTERRUPT_INDICATION & ~INDICATION_CLEAR) | zero;
    end

    // RQ19: capture flags, same set-over-clear rule
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            CAPTURE_FLAG <= '0;
        else
            CAPTURE_FLAG <= (CAPTURE_FLAG & ~CAPTURE_FLAG_CLEAR) | cap_set;
    end

    // RQ18: per-channel lines merged to one group line
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            GROUP_INTERRUPT <= 1'b0;
        else
            GROUP_INTERRUPT <= |((INTERRUPT_INDICATION & INTERRUPT_ENABLE_BITS)
                | CAPTURE_FLAG);
    end

    // ==========================================================
    // dead zone: any change of the even comparator starts a gap
    // that holds both pair outputs low, so only rising edges move
    // RQ13 RQ23: gap counts interval ticks of the even channel
    always_ff @(posedge CLOCK)
    begin
        for (int p = 0; p < NPAIR; p++)
        begin
            if (RST)
            begin
                dz_cnt_ff[p] <= ppct_pkg::DZ_RST;
                raw_prev_ff[p] <= 1'b0;
            end
            else
            begin
                raw_prev_ff[p] <= high[2*p];
                if (high[2*p] != raw_prev_ff[p])
                    dz_cnt_ff[p] <= (p == 0) ? DEADZONE_INTERVAL_01 : DEADZONE_INTERVAL_23;
                else if (tick[2*p] && dz_cnt_ff[p] != '0)
                    dz_cnt_ff[p] <= dz_cnt_ff[p] - 8'h01;
            end
        end
    end

    // a zero interval gives no gap at all
    assign gap[0] = (DEADZONE_INTERVAL_01 != '0)
        && ((high[0] != raw_prev_ff[0]) || dz_cnt_ff[0] != '0);
    assign gap[1] = (DEADZONE_INTERVAL_23 != '0)
        && ((high[2] != raw_prev_ff[1]) || dz_cnt_ff[1] != '0);

    // ==========================================================
    // output select per channel
    // RQ1 RQ4: pair mode drives odd as complement of even
    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            if (!PAIR_DEADZONE_ENABLE[c / 2])
                nxt_pwm[c] = high[c];
            else if (c % 2 == 0)
                nxt_pwm[c] = high[c] && !gap[c / 2];
            else
                nxt_pwm[c] = !high[c-1] && CHANNEL_RUN_ENABLE[c-1] && !gap[c / 2];
            // a capture pin never drives
            if (cap_en[c])
                nxt_pwm[c] = 1'b0;
        end
    end

    // RQ21: output flop follows high, so a run clear reaches the pin two clocks later (one for a pair's odd output)
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            PWM_OUT <= '0;
            PWM_OE <= '0;
        end
        else
        begin
            PWM_OUT <= nxt_pwm;
            PWM_OE <= PIN_OUTPUT_ENABLE & ~CAPTURE_INPUT_ENABLE & ~cap_en;
        end
    end

    // readbacks come straight from the counter and latch flops
    assign COUNTER_READBACK0 = cnt[0];
    assign COUNTER_READBACK1 = cnt[1];
    assign COUNTER_READBACK2 = cnt[2];
    assign COUNTER_READBACK3 = cnt[3];
    assign RISING_CAPTURE_LATCH0 = rise_lat_ff[0];
    assign RISING_CAPTURE_LATCH1 = rise_lat_ff[1];
    assign RISING_CAPTURE_LATCH2 = rise_lat_ff[2];
    assign RISING_CAPTURE_LATCH3 = rise_lat_ff[3];
    assign FALLING_CAPTURE_LATCH0 = fall_lat_ff[0];
    assign FALLING_CAPTURE_LATCH1 = fall_lat_ff[1];
    assign FALLING_CAPTURE_LATCH2 = fall_lat_ff[2];
    assign FALLING_CAPTURE_LATCH3 = fall_lat_ff[3];

    // ==========================================================
    // checks
    zero_flag_a: assert property ( // RQ3
        zero[0] |=> INTERRUPT_INDICATION[0])
        else $error("zero event did not set the flag");
    flag_clear_a: assert property ( // RQ19
        (INDICATION_CLEAR[1] && !zero[1]) |=> !INTERRUPT_INDICATION[1])
        else $error("write-one clear ignored");
    irq_merge_a: assert property ( // RQ18
        (|((INTERRUPT_INDICATION & INTERRUPT_ENABLE_BITS) | CAPTURE_FLAG))
        |=> GROUP_INTERRUPT)
        else $error("group interrupt missing");
    irq_mask_a: assert property ( // RQ3
        (INTERRUPT_ENABLE_BITS == '0 && CAPTURE_FLAG == '0) |=> !GROUP_INTERRUPT)
        else $error("masked flag raised group interrupt");
    cap_latch_a: assert property ( // RQ14
        rise[0] |=> RISING_CAPTURE_LATCH0 == $past(cnt[0]))
        else $error("rising latch missed counter");
    cap_flag_a: assert property ( // RQ15
        (fall[1] && CAPTURE_CONTROL_LOW[18]) |=> CAPTURE_FLAG[1])
        else $error("falling capture flag missing");
    run_stop_a: assert property ( // RQ21
        (!CHANNEL_RUN_ENABLE[0] && !PAIR_DEADZONE_ENABLE[0])[*2] |=> !PWM_OUT[0])
        else $error("output not stopped by run clear");
    dead_pair_a: assert property ( // RQ4
        PAIR_DEADZONE_ENABLE[0] [*2] |=> !(PWM_OUT[0] && PWM_OUT[1]))
        else $error("paired outputs high together");
    pre_space_a: assert property ( // RQ2
        (pre_tick[0] && PRESCALE_SETTING_01 == 8'h03 && $stable(PRESCALE_SETTING_01))
        |=> !pre_tick[0] [*3])
        else $error("prescaler tick too early");
    zero_seen_c: cover property (zero[0] ##1 INTERRUPT_INDICATION[0]);
    cap_seen_c: cover property (rise[0] ##[1:200] fall[0]);
    gap_seen_c: cover property (PAIR_DEADZONE_ENABLE[0] && gap[0] ##1 !gap[0]);
endmodule
`default_nettype wire

//--- bench/ppct_cap_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: power stage on driven pins, pulse source on released pins
module ppct_cap_src (
    input wire logic clk, // block clock
    input wire logic [3:0] oe, // pins driven by the block
    input wire logic [3:0] drv, // block pin levels
    output logic [3:0] pin // level on the pins
);
    logic [3:0] ext_ff = 4'h0;
    // pin routing
    // source only wins where the block has released the pin
    assign pin = (oe & drv) | (~oe & ext_ff);
    // one high pulse of a given cycle count, launched after an edge
    task automatic pulse(input int ch, input int high);
        @(posedge clk);
        #1 ext_ff[ch] = 1'b1;
        repeat (high) @(posedge clk);
        #1 ext_ff[ch] = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- bench/ppct_group_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// directed bench: wave shape, one-shot, flags, capture
module ppct_group_bench;
    logic clk = 0;
    logic rst = 1;
    logic [3:0] run = 0, mode = 0, pwr = 0, cwr = 0, ien = 0, iclr = 0, cclr = 0, pin_output_enable = 0;
    logic [15:0] wd = 0;
    logic [31:0] cch = 0, ccl = 0;
    logic [1:0] dzen = 0;
    logic [3:0] cin = 4'h4;
    logic [3:0] pin, pwm, oe, ind, cfl;
    logic gint;
    logic [15:0] cnt1, fl2;
    int n_fail = 0, num_checks = 0, cyc = 0, h;
    always #25 clk = ~clk;
    ppct_group u_dut (.CLOCK(clk), .RST(rst), .PRESCALE_SETTING_01(8'h00),
        .PRESCALE_SETTING_23(8'h00), .CLOCK_SELECT(12'h000), .DEADZONE_INTERVAL_01(8'h00),
        .DEADZONE_INTERVAL_23(8'h00), .PAIR_DEADZONE_ENABLE(dzen), .CHANNEL_RUN_ENABLE(run),
        .CHANNEL_RELOAD_MODE(mode), .PERIOD_WR(pwr), .COMPARE_WR(cwr), .WRITE_DATA(wd),
        .INTERRUPT_ENABLE_BITS(ien), .INDICATION_CLEAR(iclr), .CAPTURE_CONTROL_LOW(ccl),
        .CAPTURE_CONTROL_HIGH(cch), .CAPTURE_FLAG_CLEAR(cclr), .PIN_OUTPUT_ENABLE(pin_output_enable),
        .CAPTURE_INPUT_ENABLE(cin), .CAPTURE_PIN(pin), .PWM_OUT(pwm), .PWM_OE(oe),
        .INTERRUPT_INDICATION(ind), .CAPTURE_FLAG(cfl), .GROUP_INTERRUPT(gint),
        .COUNTER_READBACK0(), .COUNTER_READBACK1(cnt1), .COUNTER_READBACK2(),
        .COUNTER_READBACK3(), .RISING_CAPTURE_LATCH0(), .RISING_CAPTURE_LATCH1(),
        .RISING_CAPTURE_LATCH2(), .RISING_CAPTURE_LATCH3(), .FALLING_CAPTURE_LATCH0(),
        .FALLING_CAPTURE_LATCH1(), .FALLING_CAPTURE_LATCH2(fl2), .FALLING_CAPTURE_LATCH3());
    ppct_cap_src u_src (.clk(clk), .oe(oe), .drv(pwm), .pin(pin));
    // inputs move 1 ns after the edge so sampling never races
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle buffer write strobe
    task automatic wr(input logic [3:0] pm, input logic [3:0] cm, input logic [15:0] d);
        wd = d;
        pwr = pm;
        cwr = cm;
        cy(1);
        pwr = 0;
        cwr = 0;
    endtask
    // high cycles of one output over a window
    task automatic hi(input int ch, input int n);
        h = 0;
        repeat (n)
        begin
            cy(1);
            h += pwm[ch];
        end
    endtask
    task automatic stop_test;
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard well above the few hundred cycles used
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        cy(16);
        rst = 0;
        chk(pwm, 0);
        // configure first: period 4, compare 1, auto-reload on channel 0
        wr(4'h1, 4'h0, 16'h0004);
        wr(4'h0, 4'h1, 16'h0001);
        mode = 4'h1;
        ien = 4'h1;
        pin_output_enable = 4'h1;
        run = 4'h1;
        cy(20);
        hi(0, 50);
        chk(h, 20);
        chk(ind, 4'h1);
        chk(gint, 1);
        // new compare mid-cycle, high becomes four of five ticks
        wr(4'h0, 4'h1, 16'h0003);
        cy(12);
        hi(0, 50);
        chk(h, 40);
        run = 0;
        cy(3);
        chk(pwm, 0);
        iclr = 4'h1;
        cy(1);
        iclr = 0;
        cy(2);
        chk(ind, 0);
        chk(gint, 0);
        // one-shot on channel 1: single cycle then halt
        wr(4'h2, 4'h2, 16'h0003);
        mode = 0;
        run = 4'h2;
        cy(30);
        chk(ind, 4'h2);
        chk(cnt1, 0);
        chk(pwm, 0);
        run = 0;
        iclr = 4'h2;
        cy(1);
        iclr = 0;
        // capture on channel 2, both edges enabled, 30-cycle high pulse
        wr(4'h4, 4'h0, 16'h00c8);
        cch = 32'h0000000e;
        run = 4'h4;
        cy(10);
        u_src.pulse(2, 30);
        cy(5);
        chk(cfl, 4'h4);
        chk(fl2, 16'h00c8 + 1 - 30);
        chk(gint, 1);
        cclr = 4'h4;
        cy(1);
        cclr = 0;
        cy(2);
        chk(cfl, 0);
        stop_test();
    end
endmodule
`default_nettype wire
